// ==== fmsp_top.sv ====
`timescale 1ns/100ps
`include "fmsp_defs.svh"


module fmsp_top #(
  parameter int PORTS = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic [1:0] timer_ovf_i,
  input wire logic [1:0] rate_double_i,
  input wire logic [1:0] rxd_i,
  output logic [1:0] rxd_o,
  output logic [1:0] rxd_oe_o,
  output logic [1:0] txd_o,
  output logic [1:0] irq_o
);

  localparam logic [7:0] CTRL_ADDR [2] = '{`FMSP_CTRL0_ADDR, `FMSP_CTRL1_ADDR};
  localparam logic [7:0] BUF_ADDR [2] = '{`FMSP_BUF0_ADDR, `FMSP_BUF1_ADDR};

  ////////////////////////////////////////////////////////////////////////////
  // Oversampling prescale shared by mode 2 and the timed modes

  // Timed modes divide overflows by 32 (16 with doubling); mode 2 divides fosc
  function automatic logic [1:0] pre_last(input logic fixed, input logic dbl);
    if (fixed) begin
      pre_last = dbl ? 2'h1 : 2'h3;
    end else begin
      pre_last = dbl ? 2'h0 : 2'h1;
    end
  endfunction

  fmsp_pkg::fmsp_top_s_t r_reg;
  fmsp_pkg::fmsp_top_s_t r_next;

  fmsp_pkg::fmsp_mode_t mode [2];
  logic [1:0] tick16;
  logic [1:0] pre_src;
  logic sync_tick;
  logic sync_half;
  logic [1:0] tx_line;
  logic [1:0] tx_sclk;
  logic [1:0] tx_busy;
  logic [1:0] tx_done;
  logic [1:0] rx_sclk;
  logic [1:0] rx_done;
  logic [1:0] rx_bit9;
  logic [1:0] rx_stop;
  logic [7:0] rx_data [2];
  logic [1:0] rx_accept;
  logic [1:0] buf_wr;
  logic [1:0] go_sync;

  assign sync_tick = (r_reg.sync_cnt == `FMSP_SYNC_LAST);
  assign sync_half = (r_reg.sync_cnt == `FMSP_SYNC_HALF);

  ////////////////////////////////////////////////////////////////////////////
  // Per-port pins and engines

  genvar g;
  generate
    for (g = 0; g < PORTS; g++) begin : gen_port
      assign mode[g] = fmsp_pkg::fmsp_mode_t'({r_reg.ctrl[g][`FMSP_MODE_HI_BIT],
        r_reg.ctrl[g][`FMSP_MODE_LO_BIT]});
      // Mode 3 takes the timed path, mode 2 the fixed one
      assign pre_src[g] = (mode[g] == fmsp_pkg::FMSP_MODE_FIXED9) ? 1'b1 : timer_ovf_i[g];
      assign tick16[g] = pre_src[g] &&
        (r_reg.pre[g] == pre_last(mode[g] == fmsp_pkg::FMSP_MODE_FIXED9, rate_double_i[g]));
      assign buf_wr[g] = sfr_wr_i && (sfr_addr_i == BUF_ADDR[g]);
      assign go_sync[g] = r_reg.ctrl[g][`FMSP_REN_BIT] &&
        !r_reg.ctrl[g][`FMSP_RX_DONE_BIT];

      // Shift clock is low while either direction holds it low
      assign txd_o[g] = (mode[g] == fmsp_pkg::FMSP_MODE_SYNC) ?
        (tx_sclk[g] & rx_sclk[g]) : tx_line[g];
      assign rxd_o[g] = tx_line[g];
      assign rxd_oe_o[g] = tx_busy[g] && (mode[g] == fmsp_pkg::FMSP_MODE_SYNC);
      assign irq_o[g] = r_reg.ctrl[g][`FMSP_TX_DONE_BIT] | r_reg.ctrl[g][`FMSP_RX_DONE_BIT];

      fmsp_tx u_tx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mode_i(mode[g]),
        .tick_i(sync_tick),
        .half_i(sync_half),
        .tick16_i(tick16[g]),
        .start_i(buf_wr[g]),
        .data_i(sfr_wdata_i),
        .ninth_i(r_reg.ctrl[g][`FMSP_TX_NINTH_BIT]),
        .line_o(tx_line[g]),
        .sclk_o(tx_sclk[g]),
        .busy_o(tx_busy[g]),
        .done_o(tx_done[g])
      );

      fmsp_rx u_rx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mode_i(mode[g]),
        .tick_i(sync_tick),
        .half_i(sync_half),
        .tick16_i(tick16[g]),
        .rxd_i(rxd_i[g]),
        .ren_i(r_reg.ctrl[g][`FMSP_REN_BIT]),
        .go_sync_i(go_sync[g]),
        .sclk_o(rx_sclk[g]),
        .done_o(rx_done[g]),
        .data_o(rx_data[g]),
        .bit9_o(rx_bit9[g]),
        .stop_o(rx_stop[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Frame filter and register file

  always_comb begin
    r_next = r_reg;
    rx_accept = 2'b00;
    r_next.sync_cnt = sync_tick ? 4'h0 : 4'(r_reg.sync_cnt + 4'h1);
    for (int i = 0; i < PORTS; i++) begin
      if (tick16[i]) begin
        r_next.pre[i] = 2'h0;
      end else if (pre_src[i]) begin
        r_next.pre[i] = 2'(r_reg.pre[i] + 2'h1);
      end
      // A byte finishing while the last is unread is dropped
      if (rx_done[i] && !r_reg.ctrl[i][`FMSP_RX_DONE_BIT]) begin
        case (mode[i])
          fmsp_pkg::FMSP_MODE_SYNC: rx_accept[i] = 1'b1;
          fmsp_pkg::FMSP_MODE_ASYNC8:
            rx_accept[i] = !r_reg.ctrl[i][`FMSP_MPE_BIT] || rx_stop[i];
          fmsp_pkg::FMSP_MODE_FIXED9, fmsp_pkg::FMSP_MODE_TIMED9:
            rx_accept[i] = !r_reg.ctrl[i][`FMSP_MPE_BIT] || rx_bit9[i];
          default: rx_accept[i] = 1'b0;
        endcase
      end
      if (sfr_wr_i && sfr_addr_i == CTRL_ADDR[i]) begin
        r_next.ctrl[i] = sfr_wdata_i;
      end
      // Hardware set beats a same-cycle software clear
      if (tx_done[i]) begin
        r_next.ctrl[i][`FMSP_TX_DONE_BIT] = 1'b1;
      end
      if (rx_accept[i]) begin
        r_next.ctrl[i][`FMSP_RX_DONE_BIT] = 1'b1;
        r_next.rxbuf[i] = rx_data[i];
        if (mode[i] != fmsp_pkg::FMSP_MODE_SYNC) begin
          r_next.ctrl[i][`FMSP_RX_NINTH_BIT] = rx_bit9[i];
        end
      end
    end
    if (sfr_rd_i) begin
      r_next.rdata = 8'h00;
      for (int i = 0; i < PORTS; i++) begin
        if (sfr_addr_i == CTRL_ADDR[i]) begin
          r_next.rdata = r_reg.ctrl[i];
        end
        if (sfr_addr_i == BUF_ADDR[i]) begin
          r_next.rdata = r_reg.rxbuf[i];
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_reg <= '0;
      r_reg.ctrl <= {`FMSP_CTRL_RESET, `FMSP_CTRL_RESET};
    end else begin
      r_reg <= r_next;
    end
  end

  assign sfr_rdata_o = r_reg.rdata;

endmodule

// ==== fmsp_defs.svh ====
`ifndef FMSP_DEFS_SVH
`define FMSP_DEFS_SVH

// Register addresses in the special-function space
`define FMSP_CTRL0_ADDR 8'h98
`define FMSP_BUF0_ADDR 8'h99
`define FMSP_CTRL1_ADDR 8'hd8
`define FMSP_BUF1_ADDR 8'hd9
`define FMSP_CTRL_RESET 8'h00

// Control register field positions
`define FMSP_MODE_HI_BIT 7
`define FMSP_MODE_LO_BIT 6
`define FMSP_MPE_BIT 5
`define FMSP_REN_BIT 4
`define FMSP_TX_NINTH_BIT 3
`define FMSP_RX_NINTH_BIT 2
`define FMSP_TX_DONE_BIT 1
`define FMSP_RX_DONE_BIT 0

// Timing counts
`define FMSP_SYNC_LAST 4'hb
`define FMSP_SYNC_HALF 4'h5
`define FMSP_OVS_LAST 4'hf
`define FMSP_OVS_MID 4'h7
`define FMSP_SYNC_BITS 4'h8
`define FMSP_STOP8_IDX 4'h9
`define FMSP_STOP9_IDX 4'ha

`endif

// ==== fmsp_pkg.sv ====
package fmsp_pkg;

  typedef enum logic [1:0] {
    FMSP_MODE_SYNC = 2'b00,
    FMSP_MODE_ASYNC8 = 2'b01,
    FMSP_MODE_FIXED9 = 2'b10,
    FMSP_MODE_TIMED9 = 2'b11
  } fmsp_mode_t;

  typedef enum logic {
    FMSP_TX_IDLE = 1'b0,
    FMSP_TX_SEND = 1'b1
  } fmsp_tx_state_t;

  typedef enum logic [1:0] {
    FMSP_RX_IDLE = 2'b00,
    FMSP_RX_START = 2'b01,
    FMSP_RX_DATA = 2'b10
  } fmsp_rx_state_t;

  typedef struct packed {
    fmsp_tx_state_t st;
    logic [10:0] sh;
    logic [3:0] bits;
    logic [3:0] sub;
    logic line;
    logic sclk;
    logic done;
  } fmsp_tx_s_t;

  typedef struct packed {
    fmsp_rx_state_t st;
    logic [9:0] sh;
    logic [3:0] bits;
    logic [3:0] sub;
    logic prev;
    logic sclk;
    logic done;
    logic [7:0] data;
    logic bit9;
    logic stop;
  } fmsp_rx_s_t;

  typedef struct packed {
    logic [1:0][7:0] ctrl;
    logic [1:0][7:0] rxbuf;
    logic [7:0] rdata;
    logic [3:0] sync_cnt;
    logic [1:0][1:0] pre;
  } fmsp_top_s_t;

endpackage

// ==== fmsp_tx.sv ====
`timescale 1ns/100ps
`include "fmsp_defs.svh"

module fmsp_tx (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire fmsp_pkg::fmsp_mode_t mode_i,
  input wire logic tick_i,
  input wire logic half_i,
  input wire logic tick16_i,
  input wire logic start_i,
  input wire logic [7:0] data_i,
  input wire logic ninth_i,
  output logic line_o,
  output logic sclk_o,
  output logic busy_o,
  output logic done_o
);

  localparam fmsp_pkg::fmsp_tx_s_t TX_RST = '{st: fmsp_pkg::FMSP_TX_IDLE, sh: 11'h000,
    bits: 4'h0, sub: 4'h0, line: 1'b1, sclk: 1'b1, done: 1'b0};

  fmsp_pkg::fmsp_tx_s_t r_reg;
  fmsp_pkg::fmsp_tx_s_t r_next;
  logic [3:0] stop_idx;

  assign stop_idx = mode_i[1] ? `FMSP_STOP9_IDX : `FMSP_STOP8_IDX;

  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    case (r_reg.st)
      fmsp_pkg::FMSP_TX_IDLE: begin
        r_next.line = 1'b1;
        r_next.sclk = 1'b1;
        // Writes while a frame is under way are dropped
        if (start_i) begin
          r_next.st = fmsp_pkg::FMSP_TX_SEND;
          r_next.bits = 4'h0;
          r_next.sub = 4'h0;
          r_next.sh = {1'b1, (mode_i[1] ? ninth_i : 1'b1), data_i, 1'b0};
        end
      end
      fmsp_pkg::FMSP_TX_SEND: begin
        if (mode_i == fmsp_pkg::FMSP_MODE_SYNC) begin
          if (tick_i) begin
            if (r_reg.bits == `FMSP_SYNC_BITS) begin
              r_next.st = fmsp_pkg::FMSP_TX_IDLE;
              r_next.done = 1'b1;
              r_next.sclk = 1'b1;
              r_next.line = 1'b1;
            end else begin
              r_next.line = r_reg.sh[1];
              r_next.sh = {1'b0, r_reg.sh[10:1]};
              r_next.sclk = 1'b0;
              r_next.bits = 4'(r_reg.bits + 4'h1);
            end
          end else if (half_i) begin
            r_next.sclk = 1'b1;
          end
        end else if (tick16_i) begin
          r_next.sub = 4'(r_reg.sub + 4'h1);
          if (r_reg.sub == 4'h0) begin
            r_next.line = r_reg.sh[0];
            r_next.sh = {1'b0, r_reg.sh[10:1]};
            // Flag rises as the stop bit starts, not when it ends
            if (r_reg.bits == stop_idx) begin
              r_next.done = 1'b1;
            end
          end
          if (r_reg.sub == `FMSP_OVS_LAST) begin
            if (r_reg.bits == stop_idx) begin
              r_next.st = fmsp_pkg::FMSP_TX_IDLE;
            end else begin
              r_next.bits = 4'(r_reg.bits + 4'h1);
            end
          end
        end
      end
      default: r_next = TX_RST;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_reg <= TX_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign line_o = r_reg.line;
  assign sclk_o = r_reg.sclk;
  assign busy_o = (r_reg.st == fmsp_pkg::FMSP_TX_SEND);
  assign done_o = r_reg.done;

endmodule

// ==== fmsp_rx.sv ====
`timescale 1ns/100ps
`include "fmsp_defs.svh"

module fmsp_rx (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire fmsp_pkg::fmsp_mode_t mode_i,
  input wire logic tick_i,
  input wire logic half_i,
  input wire logic tick16_i,
  input wire logic rxd_i,
  input wire logic ren_i,
  input wire logic go_sync_i,
  output logic sclk_o,
  output logic done_o,
  output logic [7:0] data_o,
  output logic bit9_o,
  output logic stop_o
);

  localparam fmsp_pkg::fmsp_rx_s_t RX_RST = '{st: fmsp_pkg::FMSP_RX_IDLE, sh: 10'h000,
    bits: 4'h0, sub: 4'h0, prev: 1'b1, sclk: 1'b1, done: 1'b0, data: 8'h00,
    bit9: 1'b0, stop: 1'b0};

  fmsp_pkg::fmsp_rx_s_t r_reg;
  fmsp_pkg::fmsp_rx_s_t r_next;
  logic [3:0] stop_idx;

  assign stop_idx = mode_i[1] ? `FMSP_STOP8_IDX : 4'h8;

  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    if (tick16_i) begin
      r_next.prev = rxd_i;
    end
    case (r_reg.st)
      fmsp_pkg::FMSP_RX_IDLE: begin
        r_next.sclk = 1'b1;
        r_next.bits = 4'h0;
        r_next.sub = 4'h0;
        if (mode_i == fmsp_pkg::FMSP_MODE_SYNC) begin
          // Flag lands a cycle after done; no restart inside that gap
          if (go_sync_i && !r_reg.done) begin
            r_next.st = fmsp_pkg::FMSP_RX_DATA;
          end
        end else if (tick16_i && ren_i && r_reg.prev && !rxd_i) begin
          r_next.st = fmsp_pkg::FMSP_RX_START;
        end
      end
      fmsp_pkg::FMSP_RX_START: begin
        if (tick16_i) begin
          r_next.sub = 4'(r_reg.sub + 4'h1);
          // A glitch shorter than half a bit is not a start bit
          if (r_reg.sub == `FMSP_OVS_MID) begin
            r_next.st = rxd_i ? fmsp_pkg::FMSP_RX_IDLE : fmsp_pkg::FMSP_RX_DATA;
            r_next.sub = 4'h0;
          end
        end
      end
      fmsp_pkg::FMSP_RX_DATA: begin
        if (mode_i == fmsp_pkg::FMSP_MODE_SYNC) begin
          if (tick_i) begin
            if (r_reg.bits == `FMSP_SYNC_BITS) begin
              r_next.st = fmsp_pkg::FMSP_RX_IDLE;
              r_next.done = 1'b1;
              r_next.data = r_reg.sh[9:2];
              r_next.sclk = 1'b1;
            end else begin
              r_next.sclk = 1'b0;
            end
          // Sample only after a clock fall; a half point before the first tick is no bit
          end else if (half_i && !r_reg.sclk) begin
            r_next.sclk = 1'b1;
            r_next.sh = {rxd_i, r_reg.sh[9:1]};
            r_next.bits = 4'(r_reg.bits + 4'h1);
          end
        end else if (tick16_i) begin
          r_next.sub = 4'(r_reg.sub + 4'h1);
          if (r_reg.sub == `FMSP_OVS_LAST) begin
            r_next.sh = {rxd_i, r_reg.sh[9:1]};
            r_next.bits = 4'(r_reg.bits + 4'h1);
            // Sampled mid-stop: frame completes half a bit early
            if (r_reg.bits == stop_idx) begin
              r_next.st = fmsp_pkg::FMSP_RX_IDLE;
              r_next.done = 1'b1;
              r_next.stop = rxd_i;
              r_next.data = mode_i[1] ? r_reg.sh[8:1] : r_reg.sh[9:2];
              r_next.bit9 = mode_i[1] ? r_reg.sh[9] : rxd_i;
            end
          end
        end
      end
      default: r_next = RX_RST;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_reg <= RX_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sclk_o = r_reg.sclk;
  assign done_o = r_reg.done;
  assign data_o = r_reg.data;
  assign bit9_o = r_reg.bit9;
  assign stop_o = r_reg.stop;

endmodule

// ==== fmsp_checker.sv ====
`timescale 1ns/100ps
module fmsp_checker #(
  parameter int PORTS = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic [1:0] timer_ovf_i,
  input wire logic [1:0] rate_double_i,
  input wire logic [1:0] rxd_i,
  input wire logic [1:0] rxd_o,
  input wire logic [1:0] rxd_oe_o,
  input wire logic [1:0] txd_o,
  input wire logic [1:0] irq_o
);
  logic wr0, wr1, fall0, mode0, seen_reg, prev_reg;
  logic [4:0] wd0_reg;
  logic [6:0] low_reg;
  logic [3:0] ph_reg;
  assign wr0 = sfr_wr_i && sfr_addr_i == 8'h98;
  assign wr1 = sfr_wr_i && sfr_addr_i == 8'hd8;
  assign mode0 = wd0_reg[4:3] == 2'b00;
  assign fall0 = prev_reg && !txd_o[0];
  // Shadow of software-owned control bits; flags excluded since hardware sets them
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wd0_reg <= 5'h00;
      low_reg <= 7'h00;
      ph_reg <= 4'h0;
      seen_reg <= 1'b0;
      prev_reg <= 1'b1;
    end else begin
      wd0_reg <= wr0 ? sfr_wdata_i[7:3] : wd0_reg;
      low_reg <= txd_o[0] ? 7'h00 : low_reg + 7'h01;
      ph_reg <= (fall0 && mode0) || ph_reg == 4'hb ? 4'h0 : ph_reg + 4'h1;
      seen_reg <= seen_reg || (fall0 && mode0);
      prev_reg <= txd_o[0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ctrl_readback: assert property (
    sfr_rd_i && sfr_addr_i == 8'h98 |=> sfr_rdata_o[7:3] == $past(wd0_reg))
    else $error("control read differs from last write");
  a_unmapped_zero: assert property (
    sfr_rd_i && (sfr_addr_i & 8'hbe) != 8'h98 |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_stands: assert property (!sfr_rd_i |=> $stable(sfr_rdata_o))
    else $error("read data moved without a read");
  a_flag_sticky0: assert property (
    irq_o[0] && !wr0 |=> irq_o[0])
    else $error("port 0 flag dropped without a write");
  a_flag_sticky1: assert property (
    irq_o[1] && !wr1 |=> irq_o[1])
    else $error("port 1 flag dropped without a write");
  a_oe_sync_only: assert property (rxd_oe_o[0] |-> mode0)
    else $error("data line driven outside sync mode");
  a_sync_clk_low: assert property (
    fall0 && mode0 |-> (!txd_o[0])[*5] ##[1:3] txd_o[0])
    else $error("shift clock low phase wrong");
  a_sync_rate: assert property (fall0 && mode0 && seen_reg |-> ph_reg == 4'hb)
    else $error("shift clock not on twelve cycle grid");
  a_fixed_bit_len: assert property (
    $rose(txd_o[0]) && wd0_reg[4:3] == 2'b10 && !rate_double_i[0] |-> low_reg[5:0] == 6'h00)
    else $error("mode 2 bit not 64 cycles");
  c_sync_tx: cover property ($rose(rxd_oe_o[0]));
  c_sync_grid: cover property (fall0 && mode0 && seen_reg);
  c_flag1: cover property ($rose(irq_o[1]));
endmodule

bind fmsp_top fmsp_checker #(.PORTS(PORTS)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
  .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
  .timer_ovf_i(timer_ovf_i), .rate_double_i(rate_double_i), .rxd_i(rxd_i),
  .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o), .irq_o(irq_o));

// ==== fmsp_peer.sv ====
`timescale 1ns/100ps
module fmsp_peer (
  input wire logic clk_i,
  input wire logic line_i,
  input wire logic sd_i,
  output logic drv_o
);
  initial drv_o = 1'b1;
  // Idle period first so a start edge is always visible
  task automatic send(input logic [10:0] f, input int n, input int per);
    drv_o = 1'b1;
    repeat (per) @(negedge clk_i);
    for (int i = 0; i < n; i++) begin
      drv_o = f[i];
      repeat (per) @(negedge clk_i);
    end
    drv_o = 1'b1;
  endtask
  // Samples mid-bit, away from the edge where the line moves
  task automatic take(input int n, input int per, output logic [10:0] f);
    f = '0;
    @(negedge line_i);
    repeat (per / 2) @(negedge clk_i);
    for (int i = 0; i < n; i++) begin
      f[i] = line_i;
      repeat (per) @(negedge clk_i);
    end
  endtask
  // Slave only: follows the port's shift clock
  task automatic stake(output logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge line_i);
      b[i] = sd_i;
    end
  endtask
  task automatic ssend(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(negedge line_i);
      @(negedge clk_i);
      drv_o = b[i];
    end
    @(posedge line_i);
    @(negedge clk_i);
    drv_o = ~b[7];
  endtask
endmodule

// ==== tb_fmsp_top.sv ====
`timescale 1ns/100ps
module tb_fmsp_top;
  logic clk_i, rst_i, sfr_wr_i, sfr_rd_i;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
  logic [1:0] timer_ovf_i, rate_double_i, rxd_o, rxd_oe_o, txd_o, irq_o, pdrv;
  wire logic [1:0] rxd_i;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  logic [31:0] seed;
  logic [7:0] rxq[$];
  assign rxd_i = (rxd_oe_o & rxd_o) | (~rxd_oe_o & pdrv);
  fmsp_top u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .timer_ovf_i(timer_ovf_i), .rate_double_i(rate_double_i), .rxd_i(rxd_i),
    .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o), .irq_o(irq_o));
  fmsp_peer u_peer0 (.clk_i(clk_i), .line_i(txd_o[0]), .sd_i(rxd_i[0]), .drv_o(pdrv[0]));
  fmsp_peer u_peer1 (.clk_i(clk_i), .line_i(txd_o[1]), .sd_i(rxd_i[1]), .drv_o(pdrv[1]));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Port 1 overflow every second cycle: with doubling, a 32-cycle bit
  always @(negedge clk_i) timer_ovf_i <= {~timer_ovf_i[1], 1'b0};
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge clk_i);
    sfr_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(negedge clk_i);
    sfr_rd_i = 1'b0;
    d = sfr_rdata_o;
  endtask
  task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results();
    $display("counts: %0d compares, %0d mismatches", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // One send then four filtered receives on an async mode
  task automatic arun(input int p, input logic [1:0] m, input int per);
    logic [7:0] a, c, d, v;
    logic [10:0] f;
    logic b, ok;
    int n;
    a = p ? 8'hd8 : 8'h98;
    n = m[1] ? 11 : 10;
    seed = lfsr(seed);
    d = seed[7:0];
    b = seed[8];
    c = {m, 2'b00, b, 3'b000};
    wr(a, c);
    fork
      if (p) u_peer1.take(n, per, f);
      else u_peer0.take(n, per, f);
      wr(a + 8'h01, d);
    join
    chk("frame", m[1] ? {1'b1, b, d, 1'b0} : {2'b01, d, 1'b0}, f);
    rd(a, v);
    chk("tx flag", 11'(c | 8'h02), 11'(v));
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      d = seed[7:0];
      ok = k[0] | ~k[1];
      wr(a, {m, k[1], 5'b10000});
      if (p) u_peer1.send({1'b1, k[0], d, 1'b0}, n, per);
      else u_peer0.send({1'b1, k[0], d, 1'b0}, n, per);
      if (ok) rxq.push_back(d);
      rd(a, v);
      chk("rx ctrl", 11'({m, k[1], 2'b10, ok & k[0], 1'b0, ok}), 11'(v));
      if (ok) begin
        rd(a + 8'h01, v);
        chk("rx data", 11'(rxq.pop_front()), 11'(v));
      end
      wr(a, 8'h00);
    end
    $display("test async port %0d mode %0d done", p, m);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] a, d, v;
    rst_i = 1'b1;
    sfr_addr_i = 8'h00;
    sfr_wdata_i = 8'h00;
    sfr_wr_i = 1'b0;
    sfr_rd_i = 1'b0;
    timer_ovf_i = 2'b00;
    rate_double_i = 2'b10;
    seed = 32'h1ddd_e8e2;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    for (int p = 0; p < 2; p++) begin
      a = p ? 8'hd8 : 8'h98;
      rd(a, v);
      chk("ctrl reset", 11'h000, 11'(v));
      seed = lfsr(seed);
      d = seed[7:0] & 8'hef;
      wr(a, d);
      rd(a, v);
      chk("ctrl rw", 11'(d), 11'(v));
      chk("irq", 11'(d[1] | d[0]), 11'(irq_o[p]));
      wr(a, 8'h00);
    end
    rd(8'h50, v);
    chk("unmapped", 11'h000, 11'(v));
    $display("test registers done");
    seed = lfsr(seed);
    d = seed[7:0];
    fork
      u_peer0.stake(v);
      wr(8'h99, d);
    join
    chk("sync tx", 11'(d), 11'(v));
    repeat (12) @(negedge clk_i);
    rd(8'h98, v);
    chk("sync tx flag", 11'h002, 11'(v));
    // MPE and receive-ninth bits set on purpose: they must change nothing here
    wr(8'h98, 8'h34);
    seed = lfsr(seed);
    d = seed[7:0];
    u_peer0.ssend(d);
    repeat (12) @(negedge clk_i);
    rd(8'h98, v);
    chk("sync rx ctrl", 11'h035, 11'(v));
    rd(8'h99, v);
    chk("sync rx data", 11'(d), 11'(v));
    v = 8'hff;
    repeat (24) begin
      @(negedge clk_i);
      v = v & {8{txd_o[0]}};
    end
    chk("no restart", 11'h0ff, 11'(v));
    wr(8'h98, 8'h00);
    $display("test sync done");
    arun(0, 2'b10, 64);
    arun(1, 2'b01, 32);
    arun(1, 2'b11, 32);
    arun(1, 2'b10, 32);
    results();
  end
endmodule
